// ---- imv_pkg.sv ----
// Package with register map, source positions and vector constants
package imv_pkg;
   // Register offsets
   localparam logic [7:0] IMV_OFS_MASK_HIGH = 8'hdf;
   localparam logic [7:0] IMV_OFS_MASK_LOW  = 8'he0;
   localparam logic [7:0] IMV_OFS_MASK_TU   = 8'he1;
   localparam logic [7:0] IMV_OFS_VECTOR    = 8'he2;
   localparam logic [7:0] IMV_OFS_POSTED_LO = 8'he3;
   localparam logic [7:0] IMV_OFS_POSTED_TU = 8'he4;
   localparam logic [7:0] IMV_OFS_POSTED_HI = 8'he5;
   localparam logic [7:0] IMV_OFS_IRQ_STAT  = 8'he6;
   localparam logic [7:0] IMV_OFS_IRQ_MASK  = 8'he7;
   // Reset values
   localparam logic [7:0] IMV_MASK_RST      = 8'h00;
   localparam logic [7:0] IMV_VEC_RST       = 8'h00;
   // Writable bits of each mask register
   localparam logic [7:0] IMV_MASK_HIGH_USE = 8'h16;
   localparam logic [7:0] IMV_MASK_TU_USE   = 8'h7f;
   localparam logic [7:0] IMV_MASK_LOW_USE  = 8'hff;
   // Field positions in the 24-bit source word {high, tu, low}
   localparam int IMV_SRC_N        = 24;
   localparam int IMV_LO_POWER_ON_LOW_VOLTAGE_IRQ   = 0;
   localparam int IMV_LO_EXT_A     = 1;
   localparam int IMV_LO_SPI_TX    = 2;
   localparam int IMV_LO_SPI_RX    = 3;
   localparam int IMV_LO_PORT0     = 4;
   localparam int IMV_LO_EXT_B     = 5;
   localparam int IMV_LO_SLEEP     = 6;
   localparam int IMV_LO_PORT1     = 7;
   localparam int IMV_TU_EP0       = 8;
   localparam int IMV_TU_EP1       = 9;
   localparam int IMV_TU_EP2       = 10;
   localparam int IMV_TU_USB_RST   = 11;
   localparam int IMV_TU_USB_ACT   = 12;
   localparam int IMV_TU_MS_TIMER  = 13;
   localparam int IMV_TU_PIT       = 14;
   localparam int IMV_HI_CNT_WRAP  = 17;
   localparam int IMV_HI_EXT_C     = 18;
   localparam int IMV_HI_PORT2     = 20;
   // Vector = 4 * (position + 1); position 0 highest priority
   localparam logic [7:0] IMV_VEC_STEP  = 8'h04;
   localparam logic [7:0] IMV_VEC_NONE  = 8'h00;
   // Interrupt status bits of the block's own status register
   localparam int IMV_EV_PENDING = 0;
   localparam int IMV_EV_CLEARED = 1;
endpackage

// ---- imv_prio.sv ----
// Priority encoder of pending requests, registered vector output
`timescale 1ns/10ps
`default_nettype none
module imv_prio
   import imv_pkg::*;
#(
   parameter int N = IMV_SRC_N
) (
   // Clock and reset
   input  wire logic         clk_i,
   input  wire logic         rst_i,
   // Pending requests
   input  wire logic [N-1:0] pend_i,
   // Registered vector and any-pending flag
   output logic      [7:0]   vec_o,
   output logic              any_o
);
   logic [7:0] vec_nxt;
   logic       any_nxt;

   // Lowest set position wins
   always_comb begin
      vec_nxt = IMV_VEC_NONE;
      any_nxt = 1'b0;
      for (int i = N - 1; i >= 0; i--) begin
         if (pend_i[i]) begin
            vec_nxt = 8'(IMV_VEC_STEP * (i + 1));
            any_nxt = 1'b1;
         end
      end
   end

   // Registered result
   always_ff @(posedge clk_i or posedge rst_i) begin
      if (rst_i) begin
         vec_o <= IMV_VEC_RST;
         any_o <= 1'b0;
      end else begin
         vec_o <= vec_nxt;
         any_o <= any_nxt;
      end
   end
endmodule
`default_nettype wire

// ---- imv_top.sv ----
// Interrupt mask and vector block with register port
// Functional notes
// - High mask bit 4 gates the port-2 pin source, 1 unmasks it.
// - High mask bit 2 gates external pin c and bit 1 the counter wrap source.
// - Timer/USB mask bit 6 gates the interval timer and bit 5 the millisecond timer.
// - Timer/USB mask bits 4..0 gate USB activity, USB reset and endpoints 2, 1, 0.
// - Low mask bit 7 gates port-1 pins and bit 4 port-0 pins.
// - Low mask bit 3 gates SPI receive and bit 2 SPI transmit.
// - Low mask bits 6, 5, 1, 0 gate sleep timer, pin b, pin a and power-on/low-voltage.
// - The vector register reads the highest-priority pending vector; any write clears all pending.
// - A cleared mask bit only blocks pending; the source still posts.
// - Clearing a mask bit keeps the posted request; re-setting it makes it pending.
// - Pending requests go through a priority encoder; the core takes one only with global enable.
//
// The plain strobed port was left to the implementer.
`timescale 1ns/10ps
`default_nettype none
module imv_top
   import imv_pkg::*;
#(
   parameter int N = IMV_SRC_N
) (
   // Clock and reset
   input  wire logic         clk_i,
   input  wire logic         rst_i,
   // Register port
   input  wire logic [7:0]   addr_i,
   input  wire logic [7:0]   wdata_i,
   input  wire logic         wr_i,
   input  wire logic         rd_i,
   output logic      [7:0]   rdata_o,
   // Source post pulses {high, tu, low}
   input  wire logic [N-1:0] post_i,
   // Core side
   input  wire logic         global_irq_enable_i,
   output logic              core_irq_o,
   output logic      [7:0]   core_vec_o,
   // Block interrupt
   output logic              irq_o
);
   logic [7:0]   mask_high_sources_r;
   logic [7:0]   mask_low_sources_r;
   logic [7:0]   mask_timer_usb_sources_r;
   logic [N-1:0] posted_r;
   logic [N-1:0] posted_nxt;
   logic [1:0]   stat_r;
   logic [1:0]   stat_nxt;
   logic [1:0]   imask_r;
   logic [7:0]   rdata_r;
   logic [7:0]   rdata_nxt;
   logic         core_irq_r;
   logic         irq_r;
   logic [7:0]   vec_w;
   logic         any_w;
   logic         any_d_r;

   // Address decode
   wire          wr_high   = wr_i && (addr_i == IMV_OFS_MASK_HIGH);
   wire          wr_low    = wr_i && (addr_i == IMV_OFS_MASK_LOW);
   wire          wr_tu     = wr_i && (addr_i == IMV_OFS_MASK_TU);
   wire          wr_vec    = wr_i && (addr_i == IMV_OFS_VECTOR);
   wire          wr_istat  = wr_i && (addr_i == IMV_OFS_IRQ_STAT);
   wire          wr_imask  = wr_i && (addr_i == IMV_OFS_IRQ_MASK);
   wire [N-1:0]  mask_all  = {mask_high_sources_r, mask_timer_usb_sources_r, mask_low_sources_r};

   // Pending is posted and unmasked; mask never touches posted
   wire [N-1:0]  pending_w = posted_r & mask_all;

   // Posting; new posts win over a vector write
   assign posted_nxt = (wr_vec ? {N{1'b0}} : posted_r) | post_i;

   // Block events: became pending, software clear
   wire          ev_pend   = any_w && !any_d_r;
   assign stat_nxt = (stat_r & ~(wr_istat ? wdata_i[1:0] : 2'b00)) | {wr_vec, ev_pend};

   // Read mux
   assign rdata_nxt = !rd_i ? 8'h00 :
                      (addr_i == IMV_OFS_MASK_HIGH) ? mask_high_sources_r :
                      (addr_i == IMV_OFS_MASK_LOW)  ? mask_low_sources_r :
                      (addr_i == IMV_OFS_MASK_TU)   ? mask_timer_usb_sources_r :
                      (addr_i == IMV_OFS_VECTOR)    ? vec_w :
                      (addr_i == IMV_OFS_POSTED_LO) ? posted_r[7:0] :
                      (addr_i == IMV_OFS_POSTED_TU) ? posted_r[15:8] :
                      (addr_i == IMV_OFS_POSTED_HI) ? posted_r[23:16] :
                      (addr_i == IMV_OFS_IRQ_STAT)  ? {6'h00, stat_r} :
                      (addr_i == IMV_OFS_IRQ_MASK)  ? {6'h00, imask_r} : 8'h00;

   // Mask registers
   always_ff @(posedge clk_i or posedge rst_i) begin
      if (rst_i) begin
         mask_high_sources_r      <= IMV_MASK_RST;
         mask_low_sources_r       <= IMV_MASK_RST;
         mask_timer_usb_sources_r <= IMV_MASK_RST;
      end else begin
         if (wr_high) begin
            mask_high_sources_r <= wdata_i & IMV_MASK_HIGH_USE;
         end
         if (wr_low) begin
            mask_low_sources_r <= wdata_i & IMV_MASK_LOW_USE;
         end
         if (wr_tu) begin
            mask_timer_usb_sources_r <= wdata_i & IMV_MASK_TU_USE;
         end
      end
   end

   // Posted requests, status, read data
   always_ff @(posedge clk_i or posedge rst_i) begin
      if (rst_i) begin
         posted_r <= '0;
         stat_r   <= 2'b00;
         imask_r  <= 2'b00;
         rdata_r  <= 8'h00;
         any_d_r  <= 1'b0;
      end else begin
         posted_r <= posted_nxt;
         stat_r   <= stat_nxt;
         rdata_r  <= rdata_nxt;
         any_d_r  <= any_w;
         if (wr_imask) begin
            imask_r <= wdata_i[1:0];
         end
      end
   end

   // Output flops
   always_ff @(posedge clk_i or posedge rst_i) begin
      if (rst_i) begin
         core_irq_r <= 1'b0;
         irq_r      <= 1'b0;
      end else begin
         core_irq_r <= any_w && global_irq_enable_i && !wr_vec;
         irq_r      <= |(stat_nxt & imask_r);
      end
   end

   // Priority encoder
   imv_prio #(
      .N      (N)
   ) u_prio (
      .clk_i  (clk_i),
      .rst_i  (rst_i),
      .pend_i (pending_w),
      .vec_o  (vec_w),
      .any_o  (any_w)
   );

   assign rdata_o    = rdata_r;
   assign core_irq_o = core_irq_r;
   assign core_vec_o = vec_w;
   assign irq_o      = irq_r;

   // Assertions
   property p_port2_gate;
      @(posedge clk_i) disable iff (rst_i)
      (posted_r[IMV_HI_PORT2] && !mask_high_sources_r[4]) |-> !pending_w[IMV_HI_PORT2];
   endproperty
   a_port2_gate: assert property (p_port2_gate) else $error("port2 pending while masked");

   property p_high_gate;
      @(posedge clk_i) disable iff (rst_i)
      (posted_r[IMV_HI_EXT_C] && mask_high_sources_r[2]) |=> (vec_w != IMV_VEC_NONE);
   endproperty
   a_high_gate: assert property (p_high_gate) else $error("pin c unmasked gave no vector");

   property p_pit_gate;
      @(posedge clk_i) disable iff (rst_i)
      (posted_r[IMV_TU_PIT] && mask_timer_usb_sources_r[6]) |-> pending_w[IMV_TU_PIT];
   endproperty
   a_pit_gate: assert property (p_pit_gate) else $error("interval timer not pending");

   property p_usb_gate;
      @(posedge clk_i) disable iff (rst_i)
      (pending_w[15:8] == (posted_r[15:8] & mask_timer_usb_sources_r));
   endproperty
   a_usb_gate: assert property (p_usb_gate) else $error("usb gating wrong");

   property p_low_gate;
      @(posedge clk_i) disable iff (rst_i)
      (posted_r[IMV_LO_POWER_ON_LOW_VOLTAGE_IRQ] && mask_low_sources_r[0]) |=> (vec_w == IMV_VEC_STEP);
   endproperty
   a_low_gate: assert property (p_low_gate) else $error("power-on vector wrong");

   property p_vec_clear;
      @(posedge clk_i) disable iff (rst_i)
      (wr_vec && post_i == '0) |=> (posted_r == '0) ##1 (vec_w == IMV_VEC_NONE);
   endproperty
   a_vec_clear: assert property (p_vec_clear) else $error("vector write did not clear");

   property p_post_masked;
      @(posedge clk_i) disable iff (rst_i)
      post_i[IMV_LO_SPI_RX] |=> posted_r[IMV_LO_SPI_RX];
   endproperty
   a_post_masked: assert property (p_post_masked) else $error("post lost");

   property p_keep_posted;
      @(posedge clk_i) disable iff (rst_i)
      (wr_low && posted_r[IMV_LO_SPI_RX] && !wr_vec) |=> posted_r[IMV_LO_SPI_RX];
   endproperty
   a_keep_posted: assert property (p_keep_posted) else $error("mask write dropped post");

   property p_gie;
      @(posedge clk_i) disable iff (rst_i)
      !global_irq_enable_i |=> !core_irq_o;
   endproperty
   a_gie: assert property (p_gie) else $error("core irq without enable");

   property p_reset;
      @(posedge clk_i) $fell(rst_i) |-> (mask_all == '0 && vec_w == IMV_VEC_NONE);
   endproperty
   a_reset: assert property (p_reset) else $error("not zero after reset");

   // Gating of whole high and low mask registers, timer mask bits 6 and 5
   property p_high_bits;
      @(posedge clk_i) disable iff (rst_i)
      (pending_w[23:16] == (posted_r[23:16] & mask_high_sources_r));
   endproperty
   a_high_bits: assert property (p_high_bits) else $error("high register gating wrong");

   property p_low_bits;
      @(posedge clk_i) disable iff (rst_i)
      (pending_w[7:0] == (posted_r[7:0] & mask_low_sources_r));
   endproperty
   a_low_bits: assert property (p_low_bits) else $error("low register gating wrong");

   property p_pit_masked;
      @(posedge clk_i) disable iff (rst_i)
      !mask_timer_usb_sources_r[6] |-> !pending_w[IMV_TU_PIT];
   endproperty
   a_pit_masked: assert property (p_pit_masked) else $error("interval timer pending while masked");

   property p_ms_gate;
      @(posedge clk_i) disable iff (rst_i)
      (posted_r[IMV_TU_MS_TIMER] && mask_timer_usb_sources_r[5]) |-> pending_w[IMV_TU_MS_TIMER];
   endproperty
   a_ms_gate: assert property (p_ms_gate) else $error("millisecond timer not pending");

   // Mask writes land with absent bits zero
   property p_mask_high_wr;
      @(posedge clk_i) disable iff (rst_i)
      wr_high |=> (mask_high_sources_r == ($past(wdata_i) & IMV_MASK_HIGH_USE));
   endproperty
   a_mask_high_wr: assert property (p_mask_high_wr) else $error("high mask write wrong");

   property p_mask_low_wr;
      @(posedge clk_i) disable iff (rst_i)
      wr_low |=> (mask_low_sources_r == ($past(wdata_i) & IMV_MASK_LOW_USE));
   endproperty
   a_mask_low_wr: assert property (p_mask_low_wr) else $error("low mask write wrong");

   property p_mask_tu_wr;
      @(posedge clk_i) disable iff (rst_i)
      wr_tu |=> (mask_timer_usb_sources_r == ($past(wdata_i) & IMV_MASK_TU_USE));
   endproperty
   a_mask_tu_wr: assert property (p_mask_tu_wr) else $error("timer usb mask write wrong");

   // Priority encoder and core request
   property p_prio_any;
      @(posedge clk_i) disable iff (rst_i)
      ((vec_w == IMV_VEC_NONE) == !any_w);
   endproperty
   a_prio_any: assert property (p_prio_any) else $error("vector and pending flag disagree");

   property p_prio_spi_tx;
      @(posedge clk_i) disable iff (rst_i)
      pending_w[IMV_LO_SPI_TX] |=> ((vec_w != IMV_VEC_NONE) && (vec_w <= IMV_VEC_STEP * 8'h03));
   endproperty
   a_prio_spi_tx: assert property (p_prio_spi_tx) else $error("lower priority vector won");

   property p_core_irq_on;
      @(posedge clk_i) disable iff (rst_i)
      (any_w && global_irq_enable_i && !wr_vec) |=> core_irq_o;
   endproperty
   a_core_irq_on: assert property (p_core_irq_on) else $error("core irq missing");

   property p_core_irq_need;
      @(posedge clk_i) disable iff (rst_i)
      core_irq_o |-> ($past(any_w) && $past(global_irq_enable_i));
   endproperty
   a_core_irq_need: assert property (p_core_irq_need) else $error("core irq without pending");

   // Vector register access
   property p_vec_read;
      @(posedge clk_i) disable iff (rst_i)
      (rd_i && (addr_i == IMV_OFS_VECTOR)) |=> (rdata_o == $past(vec_w));
   endproperty
   a_vec_read: assert property (p_vec_read) else $error("vector read wrong");

   property p_vec_any_write;
      @(posedge clk_i) disable iff (rst_i)
      wr_vec |=> (posted_r == $past(post_i));
   endproperty
   a_vec_any_write: assert property (p_vec_any_write) else $error("vector write left posts");

   // Posted requests survive mask changes
   property p_post_keep;
      @(posedge clk_i) disable iff (rst_i)
      !wr_vec |=> ((posted_r & $past(posted_r)) == $past(posted_r));
   endproperty
   a_post_keep: assert property (p_post_keep) else $error("posted request lost");

   property p_unmask_vec;
      @(posedge clk_i) disable iff (rst_i)
      ($rose(mask_low_sources_r[IMV_LO_SPI_RX]) && posted_r[IMV_LO_SPI_RX]) |=> (vec_w != IMV_VEC_NONE);
   endproperty
   a_unmask_vec: assert property (p_unmask_vec) else $error("unmask gave no vector");

   property p_reset_out;
      @(posedge clk_i) $fell(rst_i) |-> (!core_irq_o && !irq_o && (rdata_o == 8'h00));
   endproperty
   a_reset_out: assert property (p_reset_out) else $error("outputs not zero after reset");

   c_pend: cover property (@(posedge clk_i) disable iff (rst_i) any_w ##1 wr_vec);
   c_core: cover property (@(posedge clk_i) disable iff (rst_i) core_irq_o);
   c_irq:  cover property (@(posedge clk_i) disable iff (rst_i) irq_o);
   c_taken: cover property (@(posedge clk_i) disable iff (rst_i) core_irq_o && global_irq_enable_i);
   c_masked: cover property (@(posedge clk_i) disable iff (rst_i) posted_r[IMV_HI_PORT2] && !mask_high_sources_r[4]);
endmodule
`default_nettype wire

// ---- imv_partner.sv ----
// Core and interrupt source model facing the mask and vector block
`timescale 1ns/10ps
`default_nettype none
module imv_partner
   import imv_pkg::*;
(
   // Clock and reset
   input  wire logic                 clk_i,
   input  wire logic                 rst_i,
   // Requests from the bench
   input  wire logic [IMV_SRC_N-1:0] req_i,
   input  wire logic                 gie_set_i,
   // Block core side
   input  wire logic                 core_irq_i,
   input  wire logic [7:0]           core_vec_i,
   // Source posts, global enable, taken vector
   output logic      [IMV_SRC_N-1:0] post_o,
   output logic                      gie_o,
   output logic      [7:0]           taken_o
);
   // Sources pulse once; core dispatch drops the global enable
   always_ff @(posedge clk_i or posedge rst_i) begin
      if (rst_i) begin
         post_o  <= '0;
         gie_o   <= 1'b0;
         taken_o <= 8'h00;
      end else begin
         post_o <= req_i;
         if (core_irq_i && gie_o) begin
            taken_o <= core_vec_i;
            gie_o   <= 1'b0;
         end else if (gie_set_i) begin
            gie_o <= 1'b1;
         end
      end
   end
endmodule
`default_nettype wire

// ---- testbench.sv ----
// Self-checking testbench for the mask and vector block
`timescale 1ns/10ps
`default_nettype none
module testbench
   import imv_pkg::*;
;
   logic             clk_i = 1'b0;
   logic             rst_i = 1'b1;
   logic [7:0]       addr_i = 8'h00;
   logic [7:0]       wdata_i = 8'h00;
   logic             wr_i = 1'b0;
   logic             rd_i = 1'b0;
   logic [23:0]      req = 24'h000000;
   logic             gie_set = 1'b0;
   wire logic [7:0]  rdata_o;
   wire logic [7:0]  core_vec_o;
   wire logic [7:0]  taken;
   wire logic [23:0] post;
   wire logic        core_irq_o;
   wire logic        irq_o;
   wire logic        global_irq_enable;
   int               bad_count = 0;
   int               n_compared = 0;
   int               cyc = 0;
   logic [7:0]       v;

   // Clock
   always #12.5 clk_i = ~clk_i;

   imv_top uut (.clk_i(clk_i), .rst_i(rst_i), .addr_i(addr_i), .wdata_i(wdata_i), .wr_i(wr_i),
      .rd_i(rd_i), .rdata_o(rdata_o), .post_i(post), .global_irq_enable_i(global_irq_enable),
      .core_irq_o(core_irq_o), .core_vec_o(core_vec_o), .irq_o(irq_o));
   imv_partner u_part (.clk_i(clk_i), .rst_i(rst_i), .req_i(req), .gie_set_i(gie_set),
      .core_irq_i(core_irq_o), .core_vec_i(core_vec_o), .post_o(post), .gie_o(global_irq_enable), .taken_o(taken));

   task automatic complete_run;
      $display("compared %0d mismatches %0d", n_compared, bad_count);
      if (bad_count == 0 && n_compared > 0)
         $display("SIMULATION PASSED");
      else
         $display("SIMULATION FAILED");
      $finish;
   endtask

   // Hang guard
   always @(posedge clk_i) begin
      cyc++;
      if (cyc == 20000) begin
         bad_count++;
         complete_run();
      end
   end

   task automatic chk(input logic [7:0] got, input logic [7:0] exp, input string what);
      n_compared++;
      if (got !== exp) begin
         bad_count++;
         $display("MISMATCH %0t %s got %h exp %h", $time, what, got, exp);
      end
   endtask

   task automatic reg_wr(input logic [7:0] a, input logic [7:0] d);
      @(posedge clk_i);
      addr_i  <= a;
      wdata_i <= d;
      wr_i    <= 1'b1;
      @(posedge clk_i);
      wr_i <= 1'b0;
   endtask

   task automatic reg_rd(input logic [7:0] a, output logic [7:0] d);
      @(posedge clk_i);
      addr_i <= a;
      rd_i   <= 1'b1;
      @(posedge clk_i);
      rd_i <= 1'b0;
      #1 d = rdata_o;
   endtask

   task automatic fire(input logic [23:0] bits);
      @(posedge clk_i);
      req <= bits;
      @(posedge clk_i);
      req <= 24'h000000;
      repeat (4) @(posedge clk_i);
   endtask

   // Reset values, unmapped read, writable bits
   task automatic t_reset;
      logic [7:0] ofs [5] = '{8'hdf, 8'he0, 8'he1, 8'he2, 8'h10};
      logic [7:0] use_m [3] = '{IMV_MASK_HIGH_USE, IMV_MASK_LOW_USE, IMV_MASK_TU_USE};
      foreach (ofs[k]) begin
         reg_rd(ofs[k], v);
         chk(v, 8'h00, "reset read");
      end
      chk({6'h00, core_irq_o, irq_o}, 8'h00, "reset irq");
      for (int k = 0; k < 3; k++) begin
         reg_wr(ofs[k], 8'hff);
         reg_rd(ofs[k], v);
         chk(v, use_m[k], "mask bits");
         reg_wr(ofs[k], 8'h00);
      end
   endtask

   // Each source alone through its own mask bit
   task automatic t_walk;
      logic [23:0] use_all;
      logic [7:0]  a;
      use_all = {IMV_MASK_HIGH_USE, IMV_MASK_TU_USE, IMV_MASK_LOW_USE};
      for (int i = 0; i < 24; i++) begin
         if (use_all[i]) begin
            a = (i < 8) ? 8'he0 : (i < 16) ? 8'he1 : 8'hdf;
            reg_wr(a, 8'h01 << (i % 8));
            fire(24'h000001 << i);
            chk(core_vec_o, 8'((i + 1) * 4), "source vector");
            reg_wr(IMV_OFS_VECTOR, 8'h5a);
            repeat (3) @(posedge clk_i);
            chk(core_vec_o, 8'h00, "vector clear");
            reg_wr(a, 8'h00);
         end
      end
   endtask

   // Post while masked, then unmask
   task automatic t_masked;
      fire(24'h100008);
      chk(core_vec_o, 8'h00, "masked pending");
      reg_rd(IMV_OFS_POSTED_LO, v);
      chk(v, 8'h08, "masked posted");
      reg_rd(IMV_OFS_POSTED_HI, v);
      chk(v, 8'h10, "masked port2 posted");
      reg_wr(IMV_OFS_MASK_LOW, 8'h08);
      repeat (3) @(posedge clk_i);
      chk(core_vec_o, 8'h10, "unmasked vector");
      reg_wr(IMV_OFS_VECTOR, 8'h00);
      reg_wr(IMV_OFS_MASK_LOW, 8'h00);
   endtask

   // Two pending, priority and core dispatch
   task automatic t_prio;
      reg_wr(IMV_OFS_MASK_LOW, 8'h24);
      fire(24'h000024);
      chk(core_vec_o, 8'h0c, "priority vector");
      reg_rd(IMV_OFS_VECTOR, v);
      chk(v, 8'h0c, "vector read");
      chk({7'h00, core_irq_o}, 8'h00, "no enable");
      @(posedge clk_i);
      gie_set <= 1'b1;
      @(posedge clk_i);
      gie_set <= 1'b0;
      repeat (4) @(posedge clk_i);
      chk(taken, 8'h0c, "taken vector");
      reg_wr(IMV_OFS_VECTOR, 8'h00);
      reg_wr(IMV_OFS_MASK_LOW, 8'h00);
   endtask

   // Block interrupt raise, mask and clear
   task automatic t_irq;
      reg_wr(IMV_OFS_IRQ_STAT, 8'h03);
      reg_wr(IMV_OFS_IRQ_MASK, 8'h01);
      repeat (2) @(posedge clk_i);
      chk({7'h00, irq_o}, 8'h00, "irq idle");
      reg_wr(IMV_OFS_MASK_LOW, 8'h01);
      fire(24'h000001);
      chk({7'h00, irq_o}, 8'h01, "irq raised");
      reg_rd(IMV_OFS_IRQ_STAT, v);
      chk(v & 8'h01, 8'h01, "status set");
      reg_wr(IMV_OFS_IRQ_STAT, 8'h01);
      repeat (2) @(posedge clk_i);
      chk({7'h00, irq_o}, 8'h00, "irq cleared");
      reg_wr(IMV_OFS_IRQ_MASK, 8'h00);
      reg_wr(IMV_OFS_VECTOR, 8'h00);
      repeat (3) @(posedge clk_i);
      chk({7'h00, irq_o}, 8'h00, "irq masked");
      reg_wr(IMV_OFS_MASK_LOW, 8'h00);
   endtask

   // Mid-run reset clears masks, posts and vector
   task automatic t_rerst;
      reg_wr(IMV_OFS_MASK_LOW, 8'h01);
      fire(24'h000001);
      chk(core_vec_o, IMV_VEC_STEP, "pre-reset vector");
      @(posedge clk_i);
      rst_i <= 1'b1;
      repeat (2) @(posedge clk_i);
      rst_i <= 1'b0;
      chk(core_vec_o, 8'h00, "reset vector");
      reg_rd(IMV_OFS_MASK_LOW, v);
      chk(v, 8'h00, "reset mask");
      reg_rd(IMV_OFS_POSTED_LO, v);
      chk(v, 8'h00, "reset posted");
   endtask

   // Main sequence
   initial begin
      repeat (16) @(posedge clk_i);
      rst_i <= 1'b0;
      t_reset();
      t_walk();
      t_masked();
      t_prio();
      t_irq();
      t_rerst();
      complete_run();
   end
endmodule
`default_nettype wire
